// ---- include/bdp_pkg.sv ----
// Shared constants and types for the four-beat double-data-rate memory port.
package bdp_pkg;

    // ------------------------------------------------------------------
    // Organisation
    // ------------------------------------------------------------------
    localparam int LANE_W    = 9;
    localparam int DW_X36    = 36;
    localparam int DW_X18    = 18;
    localparam int BAW_X36   = 18;
    localparam int BAW_X18   = 19;
    localparam int BEAT_W    = 2;
    localparam int BURST_LEN = 4;

    // ------------------------------------------------------------------
    // Synchronised pin vector layout
    // ------------------------------------------------------------------
    localparam int PIN_K   = 0;
    localparam int PIN_KN  = 1;
    localparam int PIN_C   = 2;
    localparam int PIN_CN  = 3;
    localparam int PIN_RD  = 4;
    localparam int PIN_WR  = 5;
    localparam int PIN_DLL = 6;
    localparam int PIN_N   = 7;

    // ------------------------------------------------------------------
    // Read timing, in main or output clock rises counted after the read command
    // ------------------------------------------------------------------
    localparam int           CNT_W        = 3;
    localparam logic [2:0]   FETCH_LO_EVT = 3'h2;
    localparam logic [2:0]   FETCH_HI_EVT = 3'h3;
    localparam logic [2:0]   LIM_LO       = 3'h2;
    localparam logic [2:0]   LIM_HI       = 3'h4;
    localparam logic [2:0]   LAUNCH_FIRST = 3'h3;
    localparam logic [2:0]   LAUNCH_LAST  = 3'h6;
    localparam logic [1:0]   LAST_BEAT    = 2'h3;
    localparam int           N_TRK        = 2;
    localparam int           RBUF_DEPTH   = 8;

    typedef enum logic {
        BDP_SLOT_READ,
        BDP_SLOT_WRITE
    } bdp_slot_t;

endpackage

// ---- include/bdp_stream_if.sv ----
// Valid and ready word stream between the port core and its read buffer.
`timescale 1ns/10ps
`default_nettype none
interface bdp_stream_if #(
    parameter int W = 8
);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport source (output valid, output data, input ready);
    modport sink   (input valid, input data, output ready);
endinterface
`default_nettype wire

// ---- hw/bdp_fifo.sv ----
// Read data buffer: flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/10ps
`default_nettype none
module bdp_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 8
) (
    input  wire logic    clk,
    input  wire logic    rst,
    bdp_stream_if.sink   wr_side,
    bdp_stream_if.source rd_side
);
    localparam int PW = $clog2(DEPTH);
    localparam logic [PW:0]   FULL_CNT = (PW + 1)'(DEPTH);
    localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

    logic [W-1:0]  store [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0]   count;
    logic [PW-1:0] next_wr_ptr;
    logic [PW-1:0] next_rd_ptr;
    logic [PW:0]   next_count;
    logic          push;
    logic          pop;

    assign wr_side.ready = (count != FULL_CNT);
    assign rd_side.valid = (count != '0);
    assign rd_side.data  = store[rd_ptr];

    // --------------------------------------------------------------
    // Pointer arithmetic
    // --------------------------------------------------------------
    always_comb begin
        push        = wr_side.valid & wr_side.ready;
        pop         = rd_side.valid & rd_side.ready;
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count  = count;
        if (push) begin
            next_wr_ptr = (wr_ptr == LAST_PTR) ? '0 : wr_ptr + 1'b1;
        end
        if (pop) begin
            next_rd_ptr = (rd_ptr == LAST_PTR) ? '0 : rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            store[wr_ptr] <= wr_side.data;
        end
    end
endmodule
`default_nettype wire

// ---- hw/bdp_sram_port.sv ----
// Four-beat double-data-rate static memory port with separate data buses.
//
// Overview of operation
// - Every burst moves exactly four consecutive beats.
// - Separate input and output buses run concurrently.
// - Read and write slots alternate on main rises.
// - Main rise takes address, selects, beats one, three.
// - Both rises take masks; complement rise takes beats two, four.
// - Each lane mask gates its byte per beat.
// - A write spans two full clock cycles.
// - Beats one, three leave on output complement rises.
// - Beats two, four leave on output true rises.
// - Output clocks tied high: main clocks time output.
// - A read spans two full clock cycles.
// - Echo strobes toggle together with read data.
// - Write select is active low.
// - Read select is active low.
// - Loop bypass low disables output phase alignment.
`timescale 1ns/10ps
`default_nettype none
module bdp_sram_port #(
    parameter bit WIDE       = 1'b1,
    parameter int DW         = WIDE ? bdp_pkg::DW_X36 : bdp_pkg::DW_X18,
    parameter int BAW        = WIDE ? bdp_pkg::BAW_X36 : bdp_pkg::BAW_X18,
    parameter int STORE_AW   = BAW + bdp_pkg::BEAT_W,
    parameter int RBUF_DEPTH = bdp_pkg::RBUF_DEPTH
) (
    input  wire logic                        ref_clk,
    input  wire logic                        sys_rst,
    input  wire logic                        k_clk,
    input  wire logic                        k_clk_n,
    input  wire logic                        c_clk,
    input  wire logic                        c_clk_n,
    input  wire logic                        dll_off_n,
    input  wire logic [BAW-1:0]              addr_in,
    input  wire logic                        rd_sel_n,
    input  wire logic                        wr_sel_n,
    input  wire logic [DW/bdp_pkg::LANE_W-1:0] lane_mask_n,
    input  wire logic [DW-1:0]               data_in,
    output logic      [DW-1:0]               data_out,
    output logic                             echo_strobe,
    output logic                             echo_strobe_n,
    output logic                             dll_active,
    output logic                             rd_stall
);
    localparam int LANES = DW / bdp_pkg::LANE_W;
    localparam int WAW   = BAW + bdp_pkg::BEAT_W;
    localparam int NT    = bdp_pkg::N_TRK;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [STORE_AW-1:0] word_idx(input logic [BAW-1:0] base,
                                                    input logic [1:0]     pos);
        logic [WAW-1:0] full;
        full = {base, pos};
        return full[STORE_AW-1:0];
    endfunction

    function automatic logic [DW-1:0] merge_lanes(input logic [DW-1:0]    old_word,
                                                 input logic [DW-1:0]    new_word,
                                                 input logic [LANES-1:0] mask_n);
        logic [DW-1:0] res;
        res = old_word;
        for (int i = 0; i < LANES; i++) begin
            if (!mask_n[i]) begin
                res[i*bdp_pkg::LANE_W +: bdp_pkg::LANE_W] =
                    new_word[i*bdp_pkg::LANE_W +: bdp_pkg::LANE_W];
            end
        end
        return res;
    endfunction

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [bdp_pkg::PIN_N-1:0] pin_s1;
    logic [bdp_pkg::PIN_N-1:0] pin_s2;
    logic [bdp_pkg::PIN_N-1:0] pin_prev;
    logic [BAW-1:0]            addr_s1;
    logic [BAW-1:0]            addr_s2;
    logic [DW-1:0]             din_s1;
    logic [DW-1:0]             din_s2;
    logic [LANES-1:0]          mask_s1;
    logic [LANES-1:0]          mask_s2;

    // Data pins pass the same two stages as the clocks, so a clock edge seen
    // on the second stage sees the data that stood before it.
    always_ff @(posedge ref_clk) begin
        pin_s1   <= {dll_off_n, wr_sel_n, rd_sel_n, c_clk_n, c_clk, k_clk_n, k_clk};
        pin_s2   <= pin_s1;
        pin_prev <= pin_s2;
        addr_s1  <= addr_in;
        addr_s2  <= addr_s1;
        din_s1   <= data_in;
        din_s2   <= din_s1;
        mask_s1  <= lane_mask_n;
        mask_s2  <= mask_s1;
    end

    // ------------------------------------------------------------------
    // Edge detection and output clock selection
    // ------------------------------------------------------------------
    logic k_rise;
    logic kn_rise;
    logic c_rise;
    logic cn_rise;
    logic oc_tied;
    logic oc_rise;
    logic ocn_rise;
    logic oc_lvl;
    logic ocn_lvl;
    logic main_rise;
    logic out_rise;
    logic dll_on;

    always_comb begin
        k_rise    = pin_s2[bdp_pkg::PIN_K] & ~pin_prev[bdp_pkg::PIN_K];
        kn_rise   = pin_s2[bdp_pkg::PIN_KN] & ~pin_prev[bdp_pkg::PIN_KN];
        c_rise    = pin_s2[bdp_pkg::PIN_C] & ~pin_prev[bdp_pkg::PIN_C];
        cn_rise   = pin_s2[bdp_pkg::PIN_CN] & ~pin_prev[bdp_pkg::PIN_CN];
        // Two samples in a row guard against the crossover of a running pair.
        oc_tied   = pin_s2[bdp_pkg::PIN_C] & pin_s2[bdp_pkg::PIN_CN]
                  & pin_prev[bdp_pkg::PIN_C] & pin_prev[bdp_pkg::PIN_CN];
        oc_rise   = oc_tied ? k_rise : c_rise;
        ocn_rise  = oc_tied ? kn_rise : cn_rise;
        oc_lvl    = oc_tied ? pin_s2[bdp_pkg::PIN_K] : pin_s2[bdp_pkg::PIN_C];
        ocn_lvl   = oc_tied ? pin_s2[bdp_pkg::PIN_KN] : pin_s2[bdp_pkg::PIN_CN];
        main_rise = k_rise | kn_rise;
        out_rise  = oc_rise | ocn_rise;
        dll_on    = pin_s2[bdp_pkg::PIN_DLL];
    end

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [DW-1:0]       mem [2**STORE_AW];
    logic                mem_we;
    logic [STORE_AW-1:0] mem_widx;
    logic [DW-1:0]       mem_wdata;

    // ------------------------------------------------------------------
    // Read buffer
    // ------------------------------------------------------------------
    bdp_stream_if #(.W(DW)) fetch_if ();
    bdp_stream_if #(.W(DW)) launch_if ();

    bdp_fifo #(
        .W     (DW),
        .DEPTH (RBUF_DEPTH)
    ) u_rbuf (
        .clk     (ref_clk),
        .rst     (sys_rst),
        .wr_side (fetch_if),
        .rd_side (launch_if)
    );

    // ------------------------------------------------------------------
    // Control state
    // ------------------------------------------------------------------
    bdp_pkg::bdp_slot_t        slot;
    logic                      wq_valid;
    logic [BAW-1:0]            wq_addr;
    logic                      wb_active;
    logic [BAW-1:0]            wb_addr;
    logic [1:0]                wb_pos;
    logic [NT-1:0]             trk_busy;
    logic [BAW-1:0]            trk_base [NT];
    logic [bdp_pkg::CNT_W-1:0] trk_kcnt [NT];
    logic [bdp_pkg::CNT_W-1:0] trk_ocnt [NT];
    logic [BAW-1:0]            fetch_base;
    logic [2:0]                fetch_pos;
    logic [2:0]                fetch_lim;
    logic                      launch_d;
    logic [1:0]                echo_d;

    bdp_pkg::bdp_slot_t        next_slot;
    logic                      next_wq_valid;
    logic [BAW-1:0]            next_wq_addr;
    logic                      next_wb_active;
    logic [BAW-1:0]            next_wb_addr;
    logic [1:0]                next_wb_pos;
    logic [NT-1:0]             next_trk_busy;
    logic [BAW-1:0]            next_trk_base [NT];
    logic [bdp_pkg::CNT_W-1:0] next_trk_kcnt [NT];
    logic [bdp_pkg::CNT_W-1:0] next_trk_ocnt [NT];
    logic [BAW-1:0]            next_fetch_base;
    logic [2:0]                next_fetch_pos;
    logic [2:0]                next_fetch_lim;
    logic                      next_launch_d;
    logic [1:0]                next_echo_d;
    logic [DW-1:0]             next_data_out;
    logic                      next_echo_strobe;
    logic                      next_echo_strobe_n;
    logic                      next_rd_stall;

    logic                      rd_cmd;
    logic                      wr_cmd;
    logic                      wb_start;
    logic                      launch_evt;
    logic                      launch_now;
    logic [1:0]                cap_pos;
    logic [BAW-1:0]            cap_addr;
    logic                      trk_taken;

    assign fetch_if.valid  = fetch_pos < fetch_lim;
    assign fetch_if.data   = mem[word_idx(fetch_base, fetch_pos[1:0])];
    assign launch_if.ready = launch_now;

    always_comb begin
        next_slot      = slot;
        next_wq_valid  = wq_valid;
        next_wq_addr   = wq_addr;
        next_wb_active = wb_active;
        next_wb_addr   = wb_addr;
        next_wb_pos    = wb_pos;
        next_trk_busy  = trk_busy;
        next_trk_base  = trk_base;
        next_trk_kcnt  = trk_kcnt;
        next_trk_ocnt  = trk_ocnt;
        next_fetch_base = fetch_base;
        next_fetch_pos = fetch_pos;
        next_fetch_lim = fetch_lim;
        launch_evt     = 1'b0;
        mem_we         = 1'b0;
        trk_taken      = 1'b0;

        // Commands: one slot carries a read, the next a write.
        rd_cmd = k_rise & (slot == bdp_pkg::BDP_SLOT_READ)
               & ~pin_s2[bdp_pkg::PIN_RD];
        wr_cmd = k_rise & (slot == bdp_pkg::BDP_SLOT_WRITE)
               & ~pin_s2[bdp_pkg::PIN_WR];
        if (k_rise) begin
            next_slot = (slot == bdp_pkg::BDP_SLOT_READ) ? bdp_pkg::BDP_SLOT_WRITE
                                                         : bdp_pkg::BDP_SLOT_READ;
        end

        // Late write: the command waits one cycle for its first beat.
        wb_start = k_rise & wq_valid;
        if (k_rise) begin
            next_wq_valid = wr_cmd;
            if (wr_cmd) begin
                next_wq_addr = addr_s2;
            end
        end
        cap_pos  = wb_start ? '0 : wb_pos;
        cap_addr = wb_start ? wq_addr : wb_addr;
        if (main_rise && (wb_active || wb_start)) begin
            mem_we         = 1'b1;
            next_wb_addr   = cap_addr;
            next_wb_pos    = cap_pos + 1'b1;
            next_wb_active = (cap_pos != bdp_pkg::LAST_BEAT);
        end
        mem_widx  = word_idx(cap_addr, cap_pos);
        mem_wdata = merge_lanes(mem[mem_widx], din_s2, mask_s2);

        // Read trackers: two reads at most are ever in flight.
        for (int t = 0; t < NT; t++) begin
            if (trk_busy[t]) begin
                if (main_rise) begin
                    next_trk_kcnt[t] = trk_kcnt[t] + 1'b1;
                    // Positions are fetched only after the write beats that
                    // could still land on them have been committed.
                    if (next_trk_kcnt[t] == bdp_pkg::FETCH_LO_EVT) begin
                        next_fetch_base = trk_base[t];
                        next_fetch_pos  = '0;
                        next_fetch_lim  = bdp_pkg::LIM_LO;
                    end else if (next_trk_kcnt[t] == bdp_pkg::FETCH_HI_EVT) begin
                        next_fetch_lim  = bdp_pkg::LIM_HI;
                    end
                end
                if (out_rise) begin
                    next_trk_ocnt[t] = trk_ocnt[t] + 1'b1;
                    if (next_trk_ocnt[t] >= bdp_pkg::LAUNCH_FIRST) begin
                        launch_evt = 1'b1;
                    end
                    if (next_trk_ocnt[t] == bdp_pkg::LAUNCH_LAST) begin
                        next_trk_busy[t] = 1'b0;
                    end
                end
            end
        end
        if (rd_cmd) begin
            for (int t = NT - 1; t >= 0; t--) begin
                if (!trk_busy[t] && !trk_taken) begin
                    trk_taken        = 1'b1;
                    next_trk_busy[t] = 1'b1;
                    next_trk_base[t] = addr_s2;
                    next_trk_kcnt[t] = '0;
                    next_trk_ocnt[t] = '0;
                end
            end
        end
        if (fetch_if.valid && fetch_if.ready) begin
            next_fetch_pos = next_fetch_pos + 1'b1;
        end

        // Without the loop the launch runs one cycle late, unaligned.
        next_launch_d = launch_evt;
        next_echo_d   = {ocn_lvl, oc_lvl};
        launch_now    = dll_on ? launch_evt : launch_d;
        next_data_out = (launch_now && launch_if.valid) ? launch_if.data
                                                        : data_out;
        next_echo_strobe   = dll_on ? oc_lvl : echo_d[0];
        next_echo_strobe_n = dll_on ? ocn_lvl : echo_d[1];
        next_rd_stall      = fetch_if.valid & ~fetch_if.ready;
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            slot          <= bdp_pkg::BDP_SLOT_READ;
            wq_valid      <= 1'b0;
            wq_addr       <= '0;
            wb_active     <= 1'b0;
            wb_addr       <= '0;
            wb_pos        <= '0;
            trk_busy      <= '0;
            for (int t = 0; t < NT; t++) begin
                trk_base[t] <= '0;
                trk_kcnt[t] <= '0;
                trk_ocnt[t] <= '0;
            end
            fetch_base    <= '0;
            fetch_pos     <= '0;
            fetch_lim     <= '0;
            launch_d      <= 1'b0;
            echo_d        <= '0;
            data_out      <= '0;
            echo_strobe   <= 1'b0;
            echo_strobe_n <= 1'b0;
            dll_active    <= 1'b0;
            rd_stall      <= 1'b0;
        end else begin
            slot          <= next_slot;
            wq_valid      <= next_wq_valid;
            wq_addr       <= next_wq_addr;
            wb_active     <= next_wb_active;
            wb_addr       <= next_wb_addr;
            wb_pos        <= next_wb_pos;
            trk_busy      <= next_trk_busy;
            trk_base      <= next_trk_base;
            trk_kcnt      <= next_trk_kcnt;
            trk_ocnt      <= next_trk_ocnt;
            fetch_base    <= next_fetch_base;
            fetch_pos     <= next_fetch_pos;
            fetch_lim     <= next_fetch_lim;
            launch_d      <= next_launch_d;
            echo_d        <= next_echo_d;
            data_out      <= next_data_out;
            echo_strobe   <= next_echo_strobe;
            echo_strobe_n <= next_echo_strobe_n;
            dll_active    <= dll_on;
            rd_stall      <= next_rd_stall;
        end
    end

    // Storage holds no reset; contents are undefined until written.
    always_ff @(posedge ref_clk) begin
        if (mem_we) begin
            mem[mem_widx] <= mem_wdata;
        end
    end
endmodule
`default_nettype wire

// ---- verif/bdp_port_monitor.sv ----
// Concurrent checks on the pins of the memory port.
`timescale 1ns/10ps
`default_nettype none
module bdp_port_monitor #(
    parameter int DW = 36
) (
    input wire logic          ref_clk,
    input wire logic          sys_rst,
    input wire logic          k_clk,
    input wire logic          c_clk,
    input wire logic          c_clk_n,
    input wire logic          dll_off_n,
    input wire logic [DW-1:0] data_out,
    input wire logic          echo_strobe,
    input wire logic          echo_strobe_n,
    input wire logic          dll_active,
    input wire logic          rd_stall
);
    logic [3:0] rst_age;
    logic [3:0] oclk_age;
    logic       oclk_q;
    logic       oclk;
    // The pair that times the outputs; the age lets synchroniser latency settle first.
    assign oclk = (c_clk && c_clk_n) ? k_clk : c_clk;
    always_ff @(posedge ref_clk) begin
        oclk_q <= oclk;
        rst_age <= sys_rst ? 4'h0 : rst_age + {3'h0, rst_age != 4'hF};
        oclk_age <= (sys_rst || oclk != oclk_q) ? 4'h0 : oclk_age + {3'h0, oclk_age != 4'hF};
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    AST_RESET_OUT: assert property ($past(sys_rst) |-> data_out == '0 && !echo_strobe
        && !echo_strobe_n && !dll_active && !rd_stall) else $error("outputs not clear");
    AST_DLL_FOLLOW: assert property (rst_age > 4'h5 && $stable(dll_off_n) && dll_off_n ==
        $past(dll_off_n, 2) && dll_off_n == $past(dll_off_n, 3) |-> dll_active == dll_off_n)
        else $error("dll_active wrong");
    AST_NO_STALL: assert property (!rd_stall) else $error("read stall");
    AST_ECHO_PAIR: assert property (rst_age > 4'h5 |-> echo_strobe != echo_strobe_n)
        else $error("echo pair not complementary");
    AST_ECHO_FOLLOW: assert property (rst_age > 4'h5 && oclk_age > 4'h4
        |-> echo_strobe == oclk_q) else $error("echo not following output clock");
    AST_DATA_SPACING: assert property ($changed(data_out) |=> $stable(data_out)[*3])
        else $error("data_out changed too soon");
    AST_ECHO_SPACING: assert property ($changed(echo_strobe) |=> $stable(echo_strobe)[*3])
        else $error("echo changed too soon");
    AST_DATA_WITH_ECHO: assert property ($changed(data_out)
        |-> echo_strobe != $past(echo_strobe, 3)) else $error("data moved without echo");
    cover property ($changed(data_out) && c_clk && c_clk_n);
    cover property ($changed(data_out) && !c_clk);
    cover property ($changed(data_out) && !dll_off_n);
endmodule
bind bdp_sram_port bdp_port_monitor #(.DW(DW)) bdp_port_monitor_inst (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .k_clk(k_clk), .c_clk(c_clk), .c_clk_n(c_clk_n),
    .dll_off_n(dll_off_n), .data_out(data_out), .echo_strobe(echo_strobe),
    .echo_strobe_n(echo_strobe_n), .dll_active(dll_active), .rd_stall(rd_stall));
`default_nettype wire

// ---- verif/bdp_host_model.sv ----
// Memory controller model that plays a scripted schedule of link half cycles.
`timescale 1ns/10ps
`default_nettype none
module bdp_host_model #(
    parameter int DW  = 36,
    parameter int BAW = 18,
    parameter int NH  = 44
) (
    output logic                          k_clk,
    output logic                          k_clk_n,
    output logic                          c_clk,
    output logic                          c_clk_n,
    output logic [BAW-1:0]                addr_in,
    output logic                          rd_sel_n,
    output logic                          wr_sel_n,
    output logic [DW/bdp_pkg::LANE_W-1:0] lane_mask_n,
    output logic [DW-1:0]                 data_in
);
    logic [BAW-1:0]                ad [NH];
    logic                          rs [NH];
    logic                          ws [NH];
    logic [DW-1:0]                 dq [NH];
    logic [DW/bdp_pkg::LANE_W-1:0] mk [NH];
    logic                          tie_c = 1'b1;
    assign c_clk = tie_c | k_clk;
    assign c_clk_n = tie_c | k_clk_n;
    initial begin
        k_clk = 1'b0;
        k_clk_n = 1'b1;
        {rd_sel_n, wr_sel_n, addr_in, lane_mask_n, data_in} = '1;
    end
    // Unused slots carry a pattern that flips every half, so nothing stale looks valid.
    task automatic clear();
        for (int h = 0; h < NH; h++) begin
            ad[h] = BAW'(h);
            rs[h] = 1'b1;
            ws[h] = 1'b1;
            dq[h] = {DW{h[0]}};
            mk[h] = {(DW/bdp_pkg::LANE_W){h[0]}};
        end
    endtask
    // Lines change mid-half; the clock stands still with the main clock low and its complement high between runs.
    task automatic run(input int n);
        for (int h = 0; h < n; h++) begin
            #31.25;
            addr_in <= ad[h];
            rd_sel_n <= rs[h];
            wr_sel_n <= ws[h];
            data_in <= dq[h];
            lane_mask_n <= mk[h];
            #31.25;
            k_clk <= ~h[0];
            k_clk_n <= h[0];
        end
    endtask
endmodule
`default_nettype wire

// ---- verif/test_bdp_sram_port.sv ----
// Self-checking bench for the four-beat memory port.
`timescale 1ns/10ps
`default_nettype none
module test_bdp_sram_port;
    localparam int DW = 36;
    localparam int BAW = 18;
    typedef struct {logic [BAW-1:0] a; logic [6:0] s; logic [3:0] m;} bdp_row_t;
    bdp_row_t rows [6] = '{'{18'h00000, 7'h11, 4'h0}, '{18'h00001, 7'h22, 4'h0},
        '{18'h3FFFF, 7'h33, 4'h0}, '{18'h00001, 7'h44, 4'hA}, '{18'h3FFFF, 7'h55, 4'h5},
        '{18'h00000, 7'h66, 4'hF}};
    logic          ref_clk = 1'b0;
    logic          sys_rst = 1'b1;
    logic          dll_off_n = 1'b1;
    wire logic     k_clk, k_clk_n, c_clk, c_clk_n, rd_sel_n, wr_sel_n;
    wire logic     echo_strobe, echo_strobe_n, dll_active, rd_stall;
    wire logic [BAW-1:0] addr_in;
    wire logic [3:0]     lane_mask_n;
    wire logic [DW-1:0]  data_in, data_out;
    logic [DW-1:0] mem [64];
    logic [DW-1:0] exp_q [$];
    logic [DW-1:0] got_q [$];
    logic [DW-1:0] prev = '0;
    int            n_fail = 0;
    int            n_compared = 0;
    always #5 ref_clk = ~ref_clk;
    bdp_sram_port #(.WIDE(1'b1), .STORE_AW(6)) bdp_sram_port_inst (.ref_clk(ref_clk),
        .sys_rst(sys_rst), .k_clk(k_clk), .k_clk_n(k_clk_n), .c_clk(c_clk), .c_clk_n(c_clk_n),
        .dll_off_n(dll_off_n), .addr_in(addr_in), .rd_sel_n(rd_sel_n), .wr_sel_n(wr_sel_n),
        .lane_mask_n(lane_mask_n), .data_in(data_in), .data_out(data_out),
        .echo_strobe(echo_strobe), .echo_strobe_n(echo_strobe_n), .dll_active(dll_active),
        .rd_stall(rd_stall));
    bdp_host_model #(.DW(DW), .BAW(BAW), .NH(44)) bdp_host_model_inst (.k_clk(k_clk),
        .k_clk_n(k_clk_n), .c_clk(c_clk), .c_clk_n(c_clk_n), .addr_in(addr_in),
        .rd_sel_n(rd_sel_n), .wr_sel_n(wr_sel_n), .lane_mask_n(lane_mask_n), .data_in(data_in));
    // Each launch is seen as a change, since consecutive beats never repeat a word.
    always @(negedge ref_clk) begin
        if (!sys_rst && data_out !== prev) begin
            got_q.push_back(data_out);
            prev = data_out;
        end
    end
    task automatic chk(input string nm, input logic [DW-1:0] e, input logic [DW-1:0] g);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input int c, input bdp_row_t r);
        logic [DW-1:0] d;
        bdp_host_model_inst.ws[2*c] = 1'b0;
        bdp_host_model_inst.ad[2*c] = r.a;
        for (int b = 0; b < 4; b++) begin
            d = {4{r.s, 2'(b)}};
            bdp_host_model_inst.dq[2*c+2+b] = d;
            bdp_host_model_inst.mk[2*c+2+b] = r.m;
            for (int l = 0; l < 4; l++) begin
                if (!r.m[l]) begin
                    mem[{r.a[3:0], 2'(b)}][9*l+:9] = d[9*l+:9];
                end
            end
        end
    endtask
    task automatic rd(input int c, input logic [BAW-1:0] a);
        bdp_host_model_inst.rs[2*c] = 1'b0;
        bdp_host_model_inst.ad[2*c] = a;
        for (int b = 0; b < 4; b++) begin
            exp_q.push_back(mem[{a[3:0], 2'(b)}]);
        end
    endtask
    task automatic results();
        if (n_fail == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        #60000;
        n_fail++;
        results();
    end
    // Passes: output pair tied high, output pair running, then loop bypassed.
    initial begin
        repeat (10) @(posedge ref_clk);
        sys_rst <= 1'b0;
        for (int p = 0; p < 3; p++) begin
            @(posedge ref_clk);
            bdp_host_model_inst.tie_c <= (p == 0);
            dll_off_n <= (p != 2);
            bdp_host_model_inst.clear();
            exp_q.delete();
            got_q.delete();
            foreach (rows[i]) begin
                wr(2 * i + 1, rows[i]);
                rd(2 * i + 2, rows[i].a);
            end
            bdp_host_model_inst.ws[28] = 1'b0;
            bdp_host_model_inst.ad[28] = rows[0].a;
            bdp_host_model_inst.rs[30] = 1'b0;
            rd(16, rows[0].a);
            repeat (8) @(posedge ref_clk);
            bdp_host_model_inst.run(44);
            repeat (20) @(posedge ref_clk);
            chk("beat count", DW'(exp_q.size()), DW'(got_q.size()));
            foreach (exp_q[i]) chk("data_out", exp_q[i], got_q[i]);
            chk("dll_active", DW'(p != 2), DW'(dll_active));
        end
        sys_rst <= 1'b1;
        repeat (10) @(posedge ref_clk);
        chk("data_out in reset", '0, data_out);
        results();
    end
endmodule
`default_nettype wire
